// *** rtl/pfc_fir_cfg.sv ***
// Configuration, tap 0/1 coefficient storage and sample path of the equaliser filter.
// Assumes one clock, synchronous reset, and remaining coefficients supplied on ports.
//
// What this block does
// - Share or merge bit set: channel B uses channel A coefficients, else its own.
// - Merge bit set: both filters form one filter over a single stream.
// - Side weight field scales side taps, LSB two to field minus 16, 0..6.
// - Side weight field resets to zero, LSB weight two to minus sixteen.
// - Mode field: 0 disabled at reset, 2 enabled, 1 and 3 reserved.
// - Tap 0 is a signed 12-bit first tap of A or merged filter.
// - Tap 1 is a signed 12-bit second tap of A or merged filter.
// - Coefficient readback always returns the coefficient MSB as zero.
// - Nine taps; center tap has 18-bit resolution, side taps 12-bit.
//
// Added by the designer: the address-and-strobe port.
`timescale 1ns/10ps
module pfc_fir_cfg (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [pfc_pkg::ADDR_W-1:0] reg_addr_i,
  input wire logic [pfc_pkg::DATA_W-1:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [pfc_pkg::DATA_W-1:0] reg_rdata_o,
  input wire logic sample_valid_i,
  input wire logic [pfc_pkg::SMP_W-1:0] sample_a_i,
  input wire logic [pfc_pkg::SMP_W-1:0] sample_b_i,
  input wire logic [pfc_pkg::NEXT_A-1:0][pfc_pkg::SIDE_W-1:0] ext_a_side_i,
  input wire logic [pfc_pkg::CTR_W-1:0] ext_a_center_i,
  input wire pfc_pkg::pfc_side_t ext_b_side_i,
  input wire logic [pfc_pkg::CTR_W-1:0] ext_b_center_i,
  output logic out_valid_o,
  output logic [pfc_pkg::SMP_W-1:0] out_a_o,
  output logic [pfc_pkg::SMP_W-1:0] out_b_o,
  output logic filter_active_o,
  output logic merge_filters_o
);

  typedef struct packed {
    logic [7:0] cfg;
    logic [pfc_pkg::DATA_W-1:0] tap0;
    logic [pfc_pkg::DATA_W-1:0] tap1;
    logic [pfc_pkg::DATA_W-1:0] rdata;
    pfc_pkg::pfc_win_t line_a;
    pfc_pkg::pfc_win_t line_b;
    logic [1:0] vld;
  } pfc_state_t;

  pfc_state_t s_q;
  pfc_state_t s_d;

  pfc_pkg::pfc_mode_t filter_mode_sel;
  logic filter_en;
  logic merge_filters;
  logic coeff_share_b_from_a;
  logic [2:0] side_coeff_weight;
  logic [2:0] scw_eff;
  logic scw_bad;
  pfc_pkg::pfc_side_t side_a;
  pfc_pkg::pfc_side_t side_b;
  logic [pfc_pkg::CTR_W-1:0] center_b;
  pfc_pkg::pfc_win_t win_a;
  pfc_pkg::pfc_win_t win_b;

  // ==========================================================================
  // Functions
  // Merged stream order is a(t), b(t), a(t+1): B is the later sample of a pair
  function automatic pfc_pkg::pfc_win_t build_win(input pfc_pkg::pfc_win_t la, input pfc_pkg::pfc_win_t lb,
                                                  input logic merged, input logic is_b);
    pfc_pkg::pfc_win_t w;
    w = '0;
    for (int k = 0; k < pfc_pkg::NTAP; k++) begin
      if (!merged) begin
        w[k] = is_b ? lb[k] : la[k];
      end else if (!is_b) begin
        w[k] = (k % 2 == 0) ? la[k / 2] : lb[(k + 1) / 2];
      end else begin
        w[k] = (k % 2 == 0) ? lb[k / 2] : la[(k - 1) / 2];
      end
    end
    return w;
  endfunction : build_win

  function automatic logic [pfc_pkg::DATA_W-1:0] read_word(input pfc_state_t s, input logic [pfc_pkg::ADDR_W-1:0] a,
                                                           input logic [3:0] stat);
    case (a)
      pfc_pkg::CFG_OFS: begin
        return pfc_pkg::DATA_W'(s.cfg);
      end
      pfc_pkg::STAT_OFS: begin
        return pfc_pkg::DATA_W'(stat);
      end
      pfc_pkg::TAP0_OFS: begin
        return s.tap0 & ~pfc_pkg::COEF_MSB_MASK;
      end
      pfc_pkg::TAP1_OFS: begin
        return s.tap1 & ~pfc_pkg::COEF_MSB_MASK;
      end
      default: begin
        return '0;
      end
    endcase
  endfunction : read_word

  // ==========================================================================
  // Configuration decode
  always_comb begin
    filter_mode_sel = pfc_pkg::pfc_mode_t'(s_q.cfg[pfc_pkg::MODE_LSB +: 2]);
    // Reserved modes behave as disabled so a bad write cannot corrupt data
    filter_en = (filter_mode_sel == pfc_pkg::PFC_MODE_ON);
    merge_filters = s_q.cfg[pfc_pkg::MERGE_BIT];
    coeff_share_b_from_a = s_q.cfg[pfc_pkg::SHARE_BIT];
    side_coeff_weight = s_q.cfg[pfc_pkg::SCW_LSB +: 3];
    scw_bad = (side_coeff_weight > pfc_pkg::SCW_MAX);
    scw_eff = scw_bad ? pfc_pkg::SCW_MAX : side_coeff_weight;
  end

  // ==========================================================================
  // Coefficient sets
  always_comb begin
    side_a = {ext_a_side_i, s_q.tap1[pfc_pkg::SIDE_W-1:0], s_q.tap0[pfc_pkg::SIDE_W-1:0]};
    if (coeff_share_b_from_a || merge_filters) begin
      side_b = side_a;
      center_b = ext_a_center_i;
    end else begin
      side_b = ext_b_side_i;
      center_b = ext_b_center_i;
    end
    win_a = build_win(s_q.line_a, s_q.line_b, merge_filters, 1'b0);
    win_b = build_win(s_q.line_a, s_q.line_b, merge_filters, 1'b1);
  end

  // ==========================================================================
  // Register port and sample delay lines
  always_comb begin
    s_d = s_q;
    s_d.rdata = '0;
    if (reg_wr_i) begin
      case (reg_addr_i)
        pfc_pkg::CFG_OFS: begin
          s_d.cfg = reg_wdata_i[7:0];
        end
        pfc_pkg::TAP0_OFS: begin
          s_d.tap0 = reg_wdata_i;
        end
        pfc_pkg::TAP1_OFS: begin
          s_d.tap1 = reg_wdata_i;
        end
        default: begin
        end
      endcase
    end
    if (reg_rd_i) begin
      s_d.rdata = read_word(s_q, reg_addr_i, {merge_filters, scw_bad,
                            (filter_mode_sel == pfc_pkg::PFC_MODE_RSV1) ||
                            (filter_mode_sel == pfc_pkg::PFC_MODE_RSV3), filter_en});
    end
    if (sample_valid_i) begin
      s_d.line_a = {s_q.line_a[pfc_pkg::NTAP-2:0], sample_a_i};
      s_d.line_b = {s_q.line_b[pfc_pkg::NTAP-2:0], sample_b_i};
    end
    s_d.vld = {s_q.vld[0], sample_valid_i};
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_q <= '0;
      s_q.cfg <= pfc_pkg::CFG_RST;
      s_q.tap0 <= pfc_pkg::TAP_RST;
      s_q.tap1 <= pfc_pkg::TAP_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // ==========================================================================
  // Filter datapath
  pfc_tap_mac u_mac_a (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .en_i(filter_en),
    .win_i(win_a),
    .side_i(side_a),
    .center_i(ext_a_center_i),
    .scw_i(scw_eff),
    .y_o(out_a_o)
  );

  pfc_tap_mac u_mac_b (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .en_i(filter_en),
    .win_i(win_b),
    .side_i(side_b),
    .center_i(center_b),
    .scw_i(scw_eff),
    .y_o(out_b_o)
  );

  assign reg_rdata_o = s_q.rdata;
  assign out_valid_o = s_q.vld[1];
  assign filter_active_o = filter_en;
  assign merge_filters_o = merge_filters;

  // ==========================================================================
  // Checks
  default clocking cb_main @(posedge clk_i); endclocking

  sequence s_write(logic [pfc_pkg::ADDR_W-1:0] a);
    reg_wr_i && (reg_addr_i == a);
  endsequence

  sequence s_read(logic [pfc_pkg::ADDR_W-1:0] a);
    reg_rd_i && (reg_addr_i == a);
  endsequence

  sequence s_bypass_sample;
    (sample_valid_i && !filter_en) ##1 !filter_en;
  endsequence

  property p_cfg_reset;
    rst_i |=> (s_q.cfg == pfc_pkg::CFG_RST && side_coeff_weight == 3'h0 && !filter_active_o);
  endproperty
  a_cfg_reset: assert property (p_cfg_reset) else $error("configuration not cleared by reset");

  property p_tap0_write;
    disable iff (rst_i)
    s_write(pfc_pkg::TAP0_OFS) |=> (side_a[0] == $past(reg_wdata_i[pfc_pkg::SIDE_W-1:0]));
  endproperty
  a_tap0_write: assert property (p_tap0_write) else $error("tap 0 write did not reach first tap");

  property p_tap1_write;
    disable iff (rst_i)
    s_write(pfc_pkg::TAP1_OFS) |=> (side_a[1] == $past(reg_wdata_i[pfc_pkg::SIDE_W-1:0]));
  endproperty
  a_tap1_write: assert property (p_tap1_write) else $error("tap 1 write did not reach second tap");

  property p_coef_readback;
    disable iff (rst_i)
    s_read(pfc_pkg::TAP0_OFS) |=> (reg_rdata_o[11] == 1'b0 && reg_rdata_o[10:0] == $past(s_q.tap0[10:0]) &&
                                   reg_rdata_o[15:12] == $past(s_q.tap0[15:12]));
  endproperty
  a_coef_readback: assert property (p_coef_readback) else $error("tap 0 readback wrong");

  property p_coef1_readback;
    disable iff (rst_i)
    s_read(pfc_pkg::TAP1_OFS) |=> (reg_rdata_o[11] == 1'b0 && reg_rdata_o[10:0] == $past(s_q.tap1[10:0]) &&
                                   reg_rdata_o[15:12] == $past(s_q.tap1[15:12]));
  endproperty
  a_coef1_readback: assert property (p_coef1_readback) else $error("tap 1 readback wrong");

  property p_status_read;
    disable iff (rst_i)
    s_read(pfc_pkg::STAT_OFS) |=>
      (reg_rdata_o[15:4] == 12'h000 && reg_rdata_o[3] == $past(merge_filters) &&
       reg_rdata_o[0] == $past(filter_en));
  endproperty
  a_status_read: assert property (p_status_read) else $error("status readback wrong");

  property p_cfg_write;
    disable iff (rst_i)
    s_write(pfc_pkg::CFG_OFS) |=> (s_q.cfg == $past(reg_wdata_i[7:0]));
  endproperty
  a_cfg_write: assert property (p_cfg_write) else $error("configuration write lost");

  property p_read_once;
    disable iff (rst_i)
    (!reg_rd_i) |=> (reg_rdata_o == '0);
  endproperty
  a_read_once: assert property (p_read_once) else $error("read data outside its cycle");

  property p_share;
    disable iff (rst_i)
    (!merge_filters) |-> (coeff_share_b_from_a ? (side_b == side_a && center_b == ext_a_center_i) :
                          (side_b == ext_b_side_i && center_b == ext_b_center_i));
  endproperty
  a_share: assert property (p_share) else $error("channel B coefficient set wrong");

  property p_merge_window;
    disable iff (rst_i)
    merge_filters |-> (win_b[1] == s_q.line_a[0] && win_a[1] == s_q.line_b[1] && side_b == side_a);
  endproperty
  a_merge_window: assert property (p_merge_window) else $error("merged stream order wrong");

  property p_scw_range;
    disable iff (rst_i)
    (scw_eff <= pfc_pkg::SCW_MAX) &&
      ((s_q.cfg[pfc_pkg::SCW_LSB +: 3] > pfc_pkg::SCW_MAX) || (scw_eff == s_q.cfg[pfc_pkg::SCW_LSB +: 3]));
  endproperty
  a_scw_range: assert property (p_scw_range) else $error("side weight outside legal range");

  property p_bypass;
    disable iff (rst_i)
    s_bypass_sample |=> (out_a_o == $past(sample_a_i, 2) && out_b_o == $past(sample_b_i, 2));
  endproperty
  a_bypass: assert property (p_bypass) else $error("disabled filter altered sample");

  property p_latency;
    disable iff (rst_i)
    sample_valid_i |-> ##2 out_valid_o;
  endproperty
  a_latency: assert property (p_latency) else $error("output valid not two cycles after input");

  // Nothing may stay in flight across a reset
  property p_reset_quiet;
    rst_i |=> (reg_rdata_o == '0 && !out_valid_o && out_a_o == '0 && out_b_o == '0);
  endproperty
  a_reset_quiet: assert property (p_reset_quiet) else $error("outputs not quiet after reset");

endmodule : pfc_fir_cfg

// *** rtl/pfc_pkg.sv ***
// Constants and types for the programmable equaliser filter configuration block.
// Assumes a single 100 MHz clock domain and a plain register port.
package pfc_pkg;

  // ==========================================================================
  // Widths
  localparam int ADDR_W = 12;
  localparam int DATA_W = 16;
  localparam int SMP_W = 12;
  localparam int SIDE_W = 12;
  localparam int CTR_W = 18;
  localparam int NTAP = 9;
  localparam int NSIDE = 8;
  localparam int NEXT_A = 6;
  localparam int CTR_IDX = 4;
  localparam int ACC_W = 36;

  // ==========================================================================
  // Register offsets
  localparam logic [ADDR_W-1:0] CFG_OFS = 12'h400;
  localparam logic [ADDR_W-1:0] STAT_OFS = 12'h401;
  localparam logic [ADDR_W-1:0] TAP0_OFS = 12'h418;
  localparam logic [ADDR_W-1:0] TAP1_OFS = 12'h41A;

  // ==========================================================================
  // Field positions and reset values
  localparam int MODE_LSB = 0;
  localparam int SCW_LSB = 2;
  localparam int MERGE_BIT = 5;
  localparam int SHARE_BIT = 6;
  localparam int STAT_ACTIVE_BIT = 0;
  localparam int STAT_RSVMODE_BIT = 1;
  localparam int STAT_SCWBAD_BIT = 2;
  localparam int STAT_MERGED_BIT = 3;
  localparam logic [7:0] CFG_RST = 8'h00;
  localparam logic [DATA_W-1:0] TAP_RST = 16'h0000;
  localparam logic [DATA_W-1:0] COEF_MSB_MASK = 16'h0800;

  // ==========================================================================
  // Arithmetic
  localparam logic [2:0] SCW_MAX = 3'h6;
  localparam int CTR_FRAC = 16;
  localparam logic [SMP_W-1:0] SMP_POS_MAX = 12'h7FF;
  localparam logic [SMP_W-1:0] SMP_NEG_MAX = 12'h800;

  // ==========================================================================
  // Types
  typedef enum logic [1:0] {
    PFC_MODE_OFF = 2'b00,
    PFC_MODE_RSV1 = 2'b01,
    PFC_MODE_ON = 2'b10,
    PFC_MODE_RSV3 = 2'b11
  } pfc_mode_t;

  typedef logic [NTAP-1:0][SMP_W-1:0] pfc_win_t;
  typedef logic [NSIDE-1:0][SIDE_W-1:0] pfc_side_t;

endpackage : pfc_pkg

// *** rtl/pfc_tap_mac.sv ***
// Nine-tap multiply-accumulate stage of the equaliser filter, one per channel.
// Assumes the window and coefficients are stable registers of the same clock.
`timescale 1ns/10ps
module pfc_tap_mac (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic en_i,
  input wire pfc_pkg::pfc_win_t win_i,
  input wire pfc_pkg::pfc_side_t side_i,
  input wire logic [pfc_pkg::CTR_W-1:0] center_i,
  input wire logic [2:0] scw_i,
  output logic [pfc_pkg::SMP_W-1:0] y_o
);

  typedef struct packed {
    logic [pfc_pkg::SMP_W-1:0] y;
  } pfc_mac_st_t;

  pfc_mac_st_t s_q;
  pfc_mac_st_t s_d;

  // Saturate instead of wrap: a wrapped sum flips the sign of a loud sample
  function automatic logic [pfc_pkg::SMP_W-1:0] sat_smp(input logic signed [pfc_pkg::ACC_W-1:0] v);
    if (v[pfc_pkg::ACC_W-1:pfc_pkg::SMP_W-1] == {(pfc_pkg::ACC_W-pfc_pkg::SMP_W+1){v[pfc_pkg::ACC_W-1]}}) begin
      return v[pfc_pkg::SMP_W-1:0];
    end
    return v[pfc_pkg::ACC_W-1] ? pfc_pkg::SMP_NEG_MAX : pfc_pkg::SMP_POS_MAX;
  endfunction : sat_smp

  // ==========================================================================
  // Datapath
  always_comb begin
    logic signed [pfc_pkg::ACC_W-1:0] acc;
    logic signed [pfc_pkg::ACC_W-1:0] prod;
    logic signed [pfc_pkg::ACC_W-1:0] scaled;
    acc = '0;
    prod = '0;
    scaled = '0;
    s_d = s_q;
    for (int i = 0; i < pfc_pkg::NTAP; i++) begin
      if (i == pfc_pkg::CTR_IDX) begin
        prod = pfc_pkg::ACC_W'($signed(win_i[i])) * pfc_pkg::ACC_W'($signed(center_i));
      end else begin
        prod = (pfc_pkg::ACC_W'($signed(win_i[i])) *
                pfc_pkg::ACC_W'($signed(side_i[(i < pfc_pkg::CTR_IDX) ? i : i - 1]))) <<< scw_i;
      end
      acc = acc + prod;
    end
    scaled = acc >>> pfc_pkg::CTR_FRAC;
    // Bypass keeps the same register stage so latency does not move
    s_d.y = en_i ? sat_smp(scaled) : win_i[0];
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign y_o = s_q.y;

  // ==========================================================================
  // Checks
  default clocking cb_mac @(posedge clk_i); endclocking

  property p_zero_coef;
    disable iff (rst_i)
    (en_i && center_i == '0 && side_i == '0) |=> (y_o == '0);
  endproperty
  a_zero_coef: assert property (p_zero_coef) else $error("zero coefficients gave nonzero output");

  property p_center_only;
    disable iff (rst_i)
    (en_i && side_i == '0 && center_i == 18'h10000) |=> (y_o == $past(win_i[pfc_pkg::CTR_IDX]));
  endproperty
  a_center_only: assert property (p_center_only) else $error("unit center tap did not pass center sample");

endmodule : pfc_tap_mac

// *** verification/pfc_fir_cfg_test.sv ***
// Self-checking bench for the equaliser filter configuration block.
// Assumes the block's plain register port and a 100 MHz clock; bench drives all ports.
`timescale 1ns/10ps
module pfc_fir_cfg_test;
  // ==========================================================================
  // Signals
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [pfc_pkg::ADDR_W-1:0] reg_addr_i = 12'h000;
  logic [pfc_pkg::DATA_W-1:0] reg_wdata_i = 16'h0000;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic [pfc_pkg::DATA_W-1:0] reg_rdata_o;
  logic sample_valid_i = 1'b0;
  logic [pfc_pkg::SMP_W-1:0] sample_a_i = 12'h000;
  logic [pfc_pkg::SMP_W-1:0] sample_b_i = 12'h000;
  logic [pfc_pkg::NEXT_A-1:0][pfc_pkg::SIDE_W-1:0] ext_a_side_i = '0;
  logic [pfc_pkg::CTR_W-1:0] ext_a_center_i = 18'h00000;
  pfc_pkg::pfc_side_t ext_b_side_i = '0;
  logic [pfc_pkg::CTR_W-1:0] ext_b_center_i = 18'h00000;
  logic out_valid_o;
  logic [pfc_pkg::SMP_W-1:0] out_a_o;
  logic [pfc_pkg::SMP_W-1:0] out_b_o;
  logic filter_active_o;
  logic merge_filters_o;
  int n_mismatch = 0;
  int tests_run = 0;
  int cycles = 0;

  `define CHK(got, exp) begin tests_run++; if ((got) !== (exp)) begin n_mismatch++; \
    $display("[FAIL] %0t got %h exp %h", $time, (got), (exp)); end end

  pfc_fir_cfg uut (
    .clk_i(clk_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
    .sample_valid_i(sample_valid_i), .sample_a_i(sample_a_i), .sample_b_i(sample_b_i),
    .ext_a_side_i(ext_a_side_i), .ext_a_center_i(ext_a_center_i), .ext_b_side_i(ext_b_side_i),
    .ext_b_center_i(ext_b_center_i), .out_valid_o(out_valid_o), .out_a_o(out_a_o),
    .out_b_o(out_b_o), .filter_active_o(filter_active_o), .merge_filters_o(merge_filters_o)
  );

  always #5 clk_i = ~clk_i;

  // ==========================================================================
  // Watchdog: whole sequence needs well under 2000 cycles
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      n_mismatch++;
      final_report();
    end
  end

  // ==========================================================================
  // Access tasks
  task automatic final_report();
    if (n_mismatch == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : final_report

  task automatic wr(input logic [11:0] a, input logic [15:0] d);
    @(posedge clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge clk_i);
    reg_wr_i <= 1'b0;
    #1;
  endtask : wr

  // Read data stands only in the cycle after the strobe
  task automatic rd(input logic [11:0] a, input logic [15:0] e);
    @(posedge clk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge clk_i);
    reg_rd_i <= 1'b0;
    #1;
    `CHK(reg_rdata_o, e)
  endtask : rd

  // One sample pair; returns once the fixed two-cycle result is visible
  task automatic push(input logic [11:0] a, input logic [11:0] b);
    @(posedge clk_i);
    sample_a_i <= a;
    sample_b_i <= b;
    sample_valid_i <= 1'b1;
    @(posedge clk_i);
    sample_valid_i <= 1'b0;
    @(posedge clk_i);
    #1;
    `CHK(out_valid_o, 1'b1)
  endtask : push

  task automatic flush();
    repeat (9) push(12'h000, 12'h000);
  endtask : flush

  function automatic logic [15:0] cfg(input int m, input int s, input bit mg, input bit sh);
    cfg = {8'h00, 1'b0, sh, mg, 3'(s), 2'(m)};
  endfunction : cfg

  // ==========================================================================
  // Main sequence
  initial begin
    logic [11:0] e;
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(pfc_pkg::CFG_OFS, 16'h0000);
    rd(pfc_pkg::TAP0_OFS, 16'h0000);
    rd(pfc_pkg::TAP1_OFS, 16'h0000);
    `CHK(filter_active_o, 1'b0)
    // Register storage and the coefficient readback quirk
    // Link enable lives outside this block and is taken as low for every write
    wr(pfc_pkg::CFG_OFS, 16'h009E);
    rd(pfc_pkg::CFG_OFS, 16'h009E);
    wr(pfc_pkg::TAP0_OFS, 16'hFFFF);
    rd(pfc_pkg::TAP0_OFS, 16'hF7FF);
    wr(pfc_pkg::TAP1_OFS, 16'h0ABC);
    rd(pfc_pkg::TAP1_OFS, 16'h02BC);
    rd(12'h410, 16'h0000);
    // Every mode code; non-enabled codes must pass samples straight through
    for (int m = 0; m < 4; m++) begin
      wr(pfc_pkg::CFG_OFS, cfg(m, 0, m[0], 1'b0));
      `CHK(filter_active_o, (m == 2))
      `CHK(merge_filters_o, m[0])
      push(12'h123, 12'h9AB);
      if (m != 2) begin
        `CHK(out_a_o, 12'h123)
        `CHK(out_b_o, 12'h9AB)
      end
    end
    // Side weight sweep on tap 0, weight 7 held at 6
    wr(pfc_pkg::TAP0_OFS, 16'h0400);
    wr(pfc_pkg::TAP1_OFS, 16'h0000);
    for (int s = 0; s < 8; s++) begin
      wr(pfc_pkg::CFG_OFS, cfg(2, s, 1'b0, 1'b1));
      flush();
      push(12'h100, 12'h100);
      e = 12'h004 << ((s > 6) ? 6 : s);
      `CHK(out_a_o, e)
      `CHK(out_b_o, e)
    end
    wr(pfc_pkg::TAP0_OFS, 16'h0C00);
    wr(pfc_pkg::CFG_OFS, cfg(2, 2, 1'b0, 1'b1));
    flush();
    push(12'h100, 12'h100);
    `CHK(out_a_o, 12'hFF0)
    // Saturation at both ends
    wr(pfc_pkg::TAP0_OFS, 16'h07FF);
    wr(pfc_pkg::CFG_OFS, cfg(2, 6, 1'b0, 1'b1));
    flush();
    push(12'h7FF, 12'h800);
    `CHK(out_a_o, 12'h7FF)
    `CHK(out_b_o, 12'h800)
    // Share off: channel B takes its own tap 0
    @(posedge clk_i);
    ext_b_side_i[0] <= 12'h200;
    wr(pfc_pkg::TAP0_OFS, 16'h0400);
    wr(pfc_pkg::CFG_OFS, cfg(2, 0, 1'b0, 1'b0));
    flush();
    push(12'h100, 12'h100);
    `CHK(out_a_o, 12'h004)
    `CHK(out_b_o, 12'h002)
    // Tap 1 alone, separate streams
    wr(pfc_pkg::TAP0_OFS, 16'h0000);
    wr(pfc_pkg::TAP1_OFS, 16'h0400);
    flush();
    push(12'h100, 12'h000);
    `CHK(out_b_o, 12'h000)
    push(12'h000, 12'h000);
    `CHK(out_a_o, 12'h004)
    // Merged: the B output sees the A sample one step older through tap 1
    wr(pfc_pkg::CFG_OFS, cfg(2, 0, 1'b1, 1'b0));
    flush();
    push(12'h100, 12'h000);
    `CHK(out_a_o, 12'h000)
    `CHK(out_b_o, 12'h004)
    // Centre tap ignores the side weight
    wr(pfc_pkg::TAP1_OFS, 16'h0000);
    @(posedge clk_i);
    ext_a_center_i <= 18'h10000;
    wr(pfc_pkg::CFG_OFS, cfg(2, 3, 1'b0, 1'b1));
    flush();
    push(12'h345, 12'h000);
    repeat (4) push(12'h000, 12'h000);
    `CHK(out_a_o, 12'h345)
    // Share off: B centre from its own port, A tap 8 from the side port
    @(posedge clk_i);
    ext_a_center_i <= 18'h00000;
    ext_a_side_i[5] <= 12'h400;
    ext_b_center_i <= 18'h08000;
    wr(pfc_pkg::CFG_OFS, cfg(2, 0, 1'b0, 1'b0));
    flush();
    push(12'h100, 12'h200);
    repeat (4) push(12'h000, 12'h000);
    `CHK(out_a_o, 12'h000)
    `CHK(out_b_o, 12'h100)
    repeat (4) push(12'h000, 12'h000);
    `CHK(out_a_o, 12'h004)
    `CHK(out_b_o, 12'h000)
    // Status view and a reset in mid-run
    wr(pfc_pkg::CFG_OFS, cfg(3, 7, 1'b1, 1'b0));
    rd(pfc_pkg::STAT_OFS, 16'h000E);
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(pfc_pkg::CFG_OFS, 16'h0000);
    rd(pfc_pkg::TAP0_OFS, 16'h0000);
    final_report();
  end
endmodule : pfc_fir_cfg_test
